// *** rtl/lts_pkg.sv ***
// Shared constants for the low-power timer hold, sync and routing registers
package lts_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned N_SYNC   = 6;
  localparam int unsigned N_PLACE  = 4;
  localparam int unsigned LOC_W    = 2;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_UPDATE_HOLD  = 8'h30;
  localparam logic [7:0] OFS_SYNC_PENDING = 8'h34;
  localparam logic [7:0] OFS_OUT_ROUTING  = 8'h40;

  // update_hold fields
  localparam int unsigned HOLD_BIT = 0;
  localparam logic        HOLD_RST = 1'b0;

  // sync_pending fields, one bit per timer register
  localparam int unsigned SP_CTRL  = 0;
  localparam int unsigned SP_CMD   = 1;
  localparam int unsigned SP_CMPA  = 2;
  localparam int unsigned SP_CMPB  = 3;
  localparam int unsigned SP_REPA  = 4;
  localparam int unsigned SP_REPB  = 5;
  localparam logic [5:0]  SP_RST   = 6'h00;

  // output_routing fields
  localparam int unsigned RT_PIN_A = 0;
  localparam int unsigned RT_PIN_B = 1;
  localparam int unsigned RT_LOC_LO = 8;
  localparam int unsigned RT_LOC_HI = 9;
  localparam logic [1:0]  RT_LOC_RST = 2'h0;
  localparam logic        RT_PIN_RST = 1'b0;

  // Timer clock ticks needed to land a written value in the timer domain
  localparam logic [1:0]  SYNC_TICKS = 2'h2;

  // One-hot placement mask for an enabled output
  function automatic logic [N_PLACE-1:0] lts_place_mask(
    input logic             en,
    input logic [LOC_W-1:0] loc
  );
    lts_place_mask = en ? (4'h1 << loc) : 4'h0;
  endfunction

endpackage

// *** rtl/lts_sync_chan.sv ***
// One register's crossing tracker: busy flag and apply pulse
`timescale 1ns/1ns
module lts_sync_chan
  import lts_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic wr_seen,
  input  wire logic hold,
  input  wire logic lf_tick,
  output logic      busy,
  output logic      apply
);

  logic       busy_reg;
  logic       busy_next;
  logic       apply_reg;
  logic       apply_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  always_comb
  begin
    busy_next  = busy_reg;
    apply_next = 1'b0;
    cnt_next   = cnt_reg;
    if (hold)
    begin
      // Held values restart together so they land on the same tick
      cnt_next = 2'h0;
    end
    else if (busy_reg && lf_tick)
    begin
      if (cnt_reg == SYNC_TICKS - 2'h1)
      begin
        busy_next  = 1'b0;
        apply_next = 1'b1;
        cnt_next   = 2'h0;
      end
      else
      begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
    // A new write wins over a clear in the same cycle
    if (wr_seen)
    begin
      // The superseded value never lands, so no apply pulse either
      busy_next  = 1'b1;
      apply_next = 1'b0;
      cnt_next   = 2'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_reg  <= 1'b0;
      apply_reg <= 1'b0;
      cnt_reg   <= 2'h0;
    end
    else
    begin
      busy_reg  <= busy_next;
      apply_reg <= apply_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign busy  = busy_reg;
  assign apply = apply_reg;

endmodule // lts_sync_chan

// *** rtl/lts_route.sv ***
// Output pin placement for the two timer outputs
`timescale 1ns/1ns
module lts_route
  import lts_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic [LOC_W-1:0]   loc,
  input  wire logic               en_a,
  input  wire logic               en_b,
  input  wire logic               timer_out_a,
  input  wire logic               timer_out_b,
  output logic      [N_PLACE-1:0] pin_a,
  output logic      [N_PLACE-1:0] pin_a_oe_b,
  output logic      [N_PLACE-1:0] pin_b,
  output logic      [N_PLACE-1:0] pin_b_oe_b
);

  logic [N_PLACE-1:0] mask_a;
  logic [N_PLACE-1:0] mask_b;
  logic [N_PLACE-1:0] pa_reg;
  logic [N_PLACE-1:0] pa_next;
  logic [N_PLACE-1:0] pb_reg;
  logic [N_PLACE-1:0] pb_next;
  logic [N_PLACE-1:0] oa_reg;
  logic [N_PLACE-1:0] oa_next;
  logic [N_PLACE-1:0] ob_reg;
  logic [N_PLACE-1:0] ob_next;

  assign mask_a = lts_place_mask(en_a, loc);
  assign mask_b = lts_place_mask(en_b, loc);

  // Unselected placements are released and driven low
  for (genvar p = 0; p < N_PLACE; p++)
  begin : g_place
    always_comb
    begin
      pa_next[p] = mask_a[p] & timer_out_a;
      oa_next[p] = ~mask_a[p];
      pb_next[p] = mask_b[p] & timer_out_b;
      ob_next[p] = ~mask_b[p];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pa_reg <= 4'h0;
      pb_reg <= 4'h0;
      oa_reg <= 4'hF;
      ob_reg <= 4'hF;
    end
    else
    begin
      pa_reg <= pa_next;
      pb_reg <= pb_next;
      oa_reg <= oa_next;
      ob_reg <= ob_next;
    end
  end

  assign pin_a      = pa_reg;
  assign pin_a_oe_b = oa_reg;
  assign pin_b      = pb_reg;
  assign pin_b_oe_b = ob_reg;

endmodule // lts_route

// *** rtl/lts_regs.sv ***
// Register bank: update hold, sync pending status and output routing
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// - While the hold bit is set no written value reaches the timer, and all held values land together once it clears.
// - Status bits 5 and 4 show a repeat count b or a value still crossing.
// - Status bits 3 and 2 show a compare b or a value still crossing.
// - Status bit 1 shows a command and bit 0 a control value still crossing.
// - Routing bits 9:8 pick one of four placements, bits 1 and 0 enable outputs b and a.
module lts_regs
  import lts_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic [N_SYNC-1:0] timer_reg_wr,
  input  wire logic              lf_tick,
  output logic      [N_SYNC-1:0] timer_apply,
  input  wire logic              timer_out_a,
  input  wire logic              timer_out_b,
  output logic      [N_PLACE-1:0] out_a_pin,
  output logic      [N_PLACE-1:0] out_a_oe_b,
  output logic      [N_PLACE-1:0] out_b_pin,
  output logic      [N_PLACE-1:0] out_b_oe_b
);

  logic              hold_reg;
  logic              hold_next;
  logic [LOC_W-1:0]  loc_reg;
  logic [LOC_W-1:0]  loc_next;
  logic              pin_a_reg;
  logic              pin_a_next;
  logic              pin_b_reg;
  logic              pin_b_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [N_SYNC-1:0] sync_pending;
  logic              wr_hold;
  logic              wr_route;

  assign wr_hold  = bus_wr && (bus_addr == OFS_UPDATE_HOLD);
  assign wr_route = bus_wr && (bus_addr == OFS_OUT_ROUTING);

  // Register writes; reserved bits are dropped on the way in
  always_comb
  begin
    hold_next  = hold_reg;
    loc_next   = loc_reg;
    pin_a_next = pin_a_reg;
    pin_b_next = pin_b_reg;
    if (wr_hold)
    begin
      hold_next = bus_wdata[HOLD_BIT];
    end
    if (wr_route)
    begin
      loc_next   = bus_wdata[RT_LOC_HI:RT_LOC_LO];
      pin_a_next = bus_wdata[RT_PIN_A];
      pin_b_next = bus_wdata[RT_PIN_B];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb
  begin
    rdata_next = '0;
    if (bus_rd)
    begin
      unique case (bus_addr)
        OFS_UPDATE_HOLD:
        begin
          rdata_next[HOLD_BIT] = hold_reg;
        end
        OFS_SYNC_PENDING:
        begin
          rdata_next[N_SYNC-1:0] = sync_pending;
        end
        OFS_OUT_ROUTING:
        begin
          rdata_next[RT_LOC_HI:RT_LOC_LO] = loc_reg;
          rdata_next[RT_PIN_B]            = pin_b_reg;
          rdata_next[RT_PIN_A]            = pin_a_reg;
        end
        default:
        begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_reg  <= HOLD_RST;
      loc_reg   <= RT_LOC_RST;
      pin_a_reg <= RT_PIN_RST;
      pin_b_reg <= RT_PIN_RST;
      rdata_reg <= '0;
    end
    else
    begin
      hold_reg  <= hold_next;
      loc_reg   <= loc_next;
      pin_a_reg <= pin_a_next;
      pin_b_reg <= pin_b_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  // One tracker per timer register; shared hold keeps them in step
  for (genvar i = 0; i < N_SYNC; i++)
  begin : g_sync
    lts_sync_chan u_chan
    (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_seen (timer_reg_wr[i]),
      .hold    (hold_reg),
      .lf_tick (lf_tick),
      .busy    (sync_pending[i]),
      .apply   (timer_apply[i])
    );
  end

  lts_route u_route
  (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .loc         (loc_reg),
    .en_a        (pin_a_reg),
    .en_b        (pin_b_reg),
    .timer_out_a (timer_out_a),
    .timer_out_b (timer_out_b),
    .pin_a       (out_a_pin),
    .pin_a_oe_b  (out_a_oe_b),
    .pin_b       (out_b_pin),
    .pin_b_oe_b  (out_b_oe_b)
  );

  chk_hold_blocks: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    hold_reg |=> (timer_apply == 6'h00))
    else $error("value applied while update hold set");

  chk_hold_together: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (timer_apply != 6'h00) && $past(sync_pending) == 6'h3F
      && $past(timer_reg_wr) == 6'h00 && $past(hold_reg, 2) == 1'b0
      |-> timer_apply == 6'h3F)
    else $error("pending values did not land together");

  chk_rep_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_REPB] |=> sync_pending[SP_REPB])
    else $error("repeat b busy not set after write");

  chk_repa_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_REPA] |=> sync_pending[SP_REPA])
    else $error("repeat a busy not set after write");

  chk_cmpa_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_CMPA] |=> sync_pending[SP_CMPA])
    else $error("compare a busy not set after write");

  chk_ctrl_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_CTRL] |=> sync_pending[SP_CTRL])
    else $error("control busy not set after write");

  chk_rdata_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !bus_rd |=> bus_rdata == 32'h0)
    else $error("read data not zero outside read answer");

  chk_hold_read: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    bus_rd && bus_addr == OFS_UPDATE_HOLD
      |=> bus_rdata == {31'h0, $past(hold_reg)})
    else $error("hold read does not show hold bit");

  chk_route_read: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    bus_rd && bus_addr == OFS_OUT_ROUTING
      |=> bus_rdata == {22'h0, $past(loc_reg), 6'h00,
                        $past(pin_b_reg), $past(pin_a_reg)})
    else $error("routing read does not show routing fields");

  chk_hold_write: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    wr_hold |=> hold_reg == $past(bus_wdata[HOLD_BIT]))
    else $error("hold bit not taken from write");

  chk_route_write: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    wr_route |=> loc_reg == $past(bus_wdata[RT_LOC_HI:RT_LOC_LO])
      && pin_a_reg == $past(bus_wdata[RT_PIN_A])
      && pin_b_reg == $past(bus_wdata[RT_PIN_B]))
    else $error("routing fields not taken from write");

  chk_hold_keeps: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    hold_reg |=> (sync_pending & $past(sync_pending)) == $past(sync_pending))
    else $error("busy bit cleared while update hold set");

  chk_apply_clears: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_apply != 6'h00 |-> (sync_pending & timer_apply) == 6'h00)
    else $error("busy bit still set when value landed");

  chk_apply_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_apply[SP_CTRL] |=> !timer_apply[SP_CTRL])
    else $error("control apply longer than one cycle");

  chk_pin_released: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (out_a_pin & out_a_oe_b) == 4'h0 && (out_b_pin & out_b_oe_b) == 4'h0)
    else $error("released placement driven high");

  chk_cmp_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_CMPB] |=> sync_pending[SP_CMPB] && !timer_apply[SP_CMPB])
    else $error("compare b busy not set after write");

  chk_cmd_busy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_CMD] && !hold_reg |=> sync_pending[SP_CMD] [*1] ##1
      (sync_pending[SP_CMD] || timer_apply[SP_CMD]))
    else $error("command busy dropped before landing");

  chk_status_read: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    bus_rd && bus_addr == OFS_SYNC_PENDING
      |=> bus_rdata == {26'h0, $past(sync_pending)})
    else $error("status read does not show pending bits");

  chk_route_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    wr_route ##2 1'b1 |-> out_a_oe_b ==
      ~lts_place_mask($past(bus_wdata[RT_PIN_A], 2),
                      $past(bus_wdata[RT_LOC_HI:RT_LOC_LO], 2)))
    else $error("output a placement wrong after routing write");

  chk_busy_clears: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $fell(sync_pending[SP_CTRL]) |-> timer_apply[SP_CTRL]
      && !$past(timer_reg_wr[SP_CTRL]))
    else $error("control busy cleared without landing");

  chk_busy_lands: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    timer_reg_wr[SP_CTRL] ##1 (!hold_reg && !timer_reg_wr[SP_CTRL]
      && lf_tick) [*2] |=> !sync_pending[SP_CTRL])
    else $error("control busy did not clear after two ticks");

endmodule // lts_regs

// *** verification/tb.sv ***
// Self-checking bench for the hold, sync pending and routing register bank
`timescale 1ns/1ns
module tb
  import lts_pkg::*;
;
  logic              ref_clk;
  logic              rst_b;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic [N_SYNC-1:0] timer_reg_wr;
  logic              lf_tick;
  logic [N_SYNC-1:0] timer_apply;
  logic              timer_out_a;
  logic              timer_out_b;
  logic [N_PLACE-1:0] out_a_pin;
  logic [N_PLACE-1:0] out_a_oe_b;
  logic [N_PLACE-1:0] out_b_pin;
  logic [N_PLACE-1:0] out_b_oe_b;
  int                error_cnt;
  int                num_checks;
  logic [7:0]        row_a [6];
  logic [31:0]       row_w [6];
  logic [31:0]       row_e [6];

  lts_regs DUT (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .bus_addr     (bus_addr),
    .bus_wdata    (bus_wdata),
    .bus_wr       (bus_wr),
    .bus_rd       (bus_rd),
    .bus_rdata    (bus_rdata),
    .timer_reg_wr (timer_reg_wr),
    .lf_tick      (lf_tick),
    .timer_apply  (timer_apply),
    .timer_out_a  (timer_out_a),
    .timer_out_b  (timer_out_b),
    .out_a_pin    (out_a_pin),
    .out_a_oe_b   (out_a_oe_b),
    .out_b_pin    (out_b_pin),
    .out_b_oe_b   (out_b_oe_b)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic wait_apply(input logic [5:0] exp);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (timer_apply !== 6'h00)
        break;
    end
    chk({26'h0, timer_apply}, {26'h0, exp});
  endtask

  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    logic [31:0] d;
    error_cnt = 0;
    num_checks = 0;
    rst_b = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    timer_reg_wr = 6'h00;
    lf_tick = 1'b0;
    timer_out_a = 1'b1;
    timer_out_b = 1'b0;
    row_a = '{8'h30, 8'h30, 8'h40, 8'h40, 8'h34, 8'h50};
    row_w = '{32'h1, 32'h0, 32'h303, 32'h201, 32'h3F, 32'hFF};
    row_e = '{32'h1, 32'h0, 32'h303, 32'h201, 32'h0, 32'h0};
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk({28'h0, out_a_oe_b}, 32'hF);
    foreach (row_a[i])
    begin
      rd(row_a[i], d);
      chk(d, 32'h0);
    end
    foreach (row_a[i])
    begin
      wr(row_a[i], row_w[i]);
      rd(row_a[i], d);
      chk(d, row_e[i]);
    end
    // Every placement, output a driven high and output b low
    for (int l = 0; l < 4; l++)
    begin
      wr(OFS_OUT_ROUTING, {22'h0, l[1:0], 8'h03});
      repeat (3) @(posedge ref_clk);
      #1;
      chk({28'h0, out_a_pin}, 32'h1 << l);
      chk({28'h0, out_a_oe_b}, ~(32'h1 << l) & 32'hF);
      chk({28'h0, out_b_pin}, 32'h0);
      chk({28'h0, out_b_oe_b}, ~(32'h1 << l) & 32'hF);
    end
    wr(OFS_OUT_ROUTING, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({24'h0, out_a_oe_b, out_b_oe_b}, 32'hFF);
    // Each channel: busy after the write, cleared when it lands
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      timer_reg_wr <= 6'h01 << i;
      @(posedge ref_clk);
      timer_reg_wr <= 6'h00;
      rd(OFS_SYNC_PENDING, d);
      chk(d, 32'h1 << i);
      lf_tick <= 1'b1;
      wait_apply(6'h01 << i);
      lf_tick <= 1'b0;
      rd(OFS_SYNC_PENDING, d);
      chk(d, 32'h0);
    end
    // Held compare writes must land in one cycle together
    wr(OFS_UPDATE_HOLD, 32'h1);
    @(posedge ref_clk);
    timer_reg_wr <= 6'h0C;
    @(posedge ref_clk);
    timer_reg_wr <= 6'h00;
    lf_tick <= 1'b1;
    repeat (5)
    begin
      @(posedge ref_clk);
      #1;
      chk({26'h0, timer_apply}, 32'h0);
    end
    rd(OFS_SYNC_PENDING, d);
    chk(d, 32'h0C);
    wr(OFS_UPDATE_HOLD, 32'h0);
    wait_apply(6'h0C);
    @(posedge ref_clk);
    #1;
    chk({26'h0, timer_apply}, 32'h0);
    lf_tick <= 1'b0;
    // A second write while busy restarts the crossing
    @(posedge ref_clk);
    timer_reg_wr <= 6'h02;
    lf_tick <= 1'b1;
    @(posedge ref_clk);
    timer_reg_wr <= 6'h02;
    @(posedge ref_clk);
    timer_reg_wr <= 6'h00;
    #1;
    chk({26'h0, timer_apply}, 32'h0);
    wait_apply(6'h02);
    lf_tick <= 1'b0;
    // Reset in mid-run clears registers and pins
    wr(OFS_OUT_ROUTING, 32'h301);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(OFS_OUT_ROUTING, d);
    chk(d, 32'h0);
    chk({28'h0, out_a_pin}, 32'h0);
    chk({28'h0, out_a_oe_b}, 32'hF);
    finish_test();
  end
endmodule // tb
